// ===== bench/lrt_initiator_model.sv
// initiator side model: sends unit reset requests and collects the responses
`timescale 1ns/100ps
module lrt_initiator_model (
  input  wire logic       hclk,
  output logic            rx_valid,
  output logic            rx_first,
  output logic [7:0]      rx_byte,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  input  wire logic [7:0] tx_byte
);
  logic [7:0] rsp [0:4];
  logic [2:0] rsp_pos;
  int         rsp_n;
  logic       outstanding;

  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_byte = 8'h00;
    rsp_pos = 3'h0;
    rsp_n = 0;
    outstanding = 1'b0;
  end

  // one request per call; the bench calls again for every logical path in use
  task automatic send_reset(input logic [15:0] tag, input logic [31:0] path, input logic [7:0] unit);
    logic [7:0] msg [0:8];
    msg = '{8'h83, 8'h35, tag[15:8], tag[7:0], path[31:24], path[23:16],
            path[15:8], path[7:0], unit};
    outstanding = 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_first <= (i == 0);
      rx_byte  <= msg[i];
    end
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    // released line must not look like a repeat of the last byte
    rx_byte  <= ~msg[8];
  endtask

  always @(posedge hclk) begin
    if (tx_valid && rsp_pos < 3'h5) begin
      rsp[rsp_pos] <= tx_byte;
      rsp_pos <= tx_last ? 3'h0 : rsp_pos + 3'h1;
      if (tx_last) begin
        rsp_n <= rsp_n + 1;
        outstanding <= 1'b0;
      end
    end
  end
endmodule

// ===== bench/lrt_unit_reset_tb_top.sv
// self-checking bench for the unit reset and task response block
`timescale 1ns/100ps
`include "lrt_defs.svh"
module lrt_unit_reset_tb_top;
  logic        hclk, hresetn, hsel, hwrite, rx_valid, rx_first, tm_valid, cmd_valid;
  logic        data_pending, link_reset, hard_reset_req, sync_char_rx, rotation_tick;
  logic        tx_valid, tx_last;
  logic        hreadyout, hresp, flush_req, unit_abort, status_block, unit_attention;
  logic        sync_char_tx, sync_servo_pulse, user_char_forward_enable, cmd_reject;
  logic [31:0] haddr, hwdata, hrdata, tm_path, cmd_path, reply_path_identifier, rd;
  logic [15:0] tm_tag, cmd_tag;
  logic [7:0]  rx_byte, tm_code, tx_byte, abort_unit;
  logic [2:0]  hsize, queue_type_field;
  logic [1:0]  htrans, spindle_sync_role_field;
  int          miscompares, checks, n_abort, n_rej, n_stx, n_servo;

  lrt_unit_reset lrt_unit_reset_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte), .tm_valid(tm_valid),
    .tm_code(tm_code), .tm_tag(tm_tag), .tm_path(tm_path), .cmd_valid(cmd_valid),
    .queue_type_field(queue_type_field), .cmd_tag(cmd_tag), .cmd_path(cmd_path),
    .data_pending(data_pending), .link_reset(link_reset), .hard_reset_req(hard_reset_req),
    .sync_char_rx(sync_char_rx), .spindle_sync_role_field(spindle_sync_role_field),
    .rotation_tick(rotation_tick), .tx_valid(tx_valid), .tx_last(tx_last), .tx_byte(tx_byte),
    .reply_path_identifier(reply_path_identifier), .flush_req(flush_req),
    .unit_abort(unit_abort), .abort_unit(abort_unit), .status_block(status_block),
    .unit_attention(unit_attention), .sync_char_tx(sync_char_tx),
    .sync_servo_pulse(sync_servo_pulse), .user_char_forward_enable(user_char_forward_enable),
    .cmd_reject(cmd_reject));

  lrt_initiator_model lrt_initiator_model_i (.hclk(hclk), .rx_valid(rx_valid),
    .rx_first(rx_first), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_byte(tx_byte));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    n_abort <= n_abort + int'(unit_abort === 1'b1);
    n_rej   <= n_rej + int'(cmd_reject === 1'b1);
    n_stx   <= n_stx + int'(sync_char_tx === 1'b1);
    n_servo <= n_servo + int'(sync_servo_pulse === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk_rsp(input int n0, input logic [15:0] tag, input logic [7:0] code);
    for (int i = 0; i < 300 && lrt_initiator_model_i.rsp_n == n0; i++) @(posedge hclk);
    repeat (20) @(posedge hclk);
    chk(32'(lrt_initiator_model_i.rsp_n - n0), 32'h1, "responses");
    chk({lrt_initiator_model_i.rsp[0], lrt_initiator_model_i.rsp[1], lrt_initiator_model_i.rsp[2],
         lrt_initiator_model_i.rsp[3]}, {`LRT_CLASS_CODE, `LRT_PC_RESPONSE, tag}, "head");
    chk(32'(lrt_initiator_model_i.rsp[4]), 32'(code), "return code");
  endtask

  task automatic t_regs;
    ahb(1'b0, 32'(`LRT_ADDR_LUNMAP), 32'h0);
    chk(32'(rd[7:0]), 32'(`LRT_LUNMAP_RESET), "unit map reset");
    ahb(1'b0, 32'(`LRT_ADDR_CTRL), 32'h0);
    chk(rd, 32'(`LRT_CTRL_RESET), "forward control reset");
    ahb(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    for (int v = 0; v < 2; v++) begin
      ahb(1'b1, 32'(`LRT_ADDR_CTRL), 32'(v));
      repeat (2) @(posedge hclk);
      chk(32'(user_char_forward_enable), 32'(v), "forward enable");
    end
    chk(32'(hresp), 32'h0, "okay response");
  endtask

  task automatic t_reset_ok;
    int n0, a0;
    ahb(1'b1, 32'(`LRT_ADDR_LUNMAP), 32'h0000_0005);
    n0 = lrt_initiator_model_i.rsp_n;
    a0 = n_abort;
    data_pending <= 1'b1;
    lrt_initiator_model_i.send_reset(16'hbeef, 32'h1234_5678, 8'h02);
    repeat (30) @(posedge hclk);
    chk(32'(flush_req), 32'h1, "flushing");
    chk(32'(n_abort - a0), 32'h0, "abort before flush done");
    chk(32'(lrt_initiator_model_i.rsp_n - n0), 32'h0, "early response");
    data_pending <= 1'b0;
    chk_rsp(n0, 16'hbeef, `LRT_RC_SUCCESS);
    chk(32'(n_abort - a0), 32'h1, "one abort");
    chk(32'(abort_unit), 32'h2, "aborted unit");
    chk(reply_path_identifier, 32'h1234_5678, "reply path");
    chk(32'(unit_attention), 32'h1, "unit attention");
  endtask

  task automatic t_reset_bad;
    logic [7:0] units [0:1] = '{8'h03, 8'h09};
    int a0;
    a0 = n_abort;
    foreach (units[i]) begin
      lrt_initiator_model_i.send_reset(16'h0a00 + 16'(i), 32'h0, units[i]);
      chk_rsp(lrt_initiator_model_i.rsp_n, 16'h0a00 + 16'(i), `LRT_RC_INVALID);
    end
    chk(32'(n_abort - a0), 32'h0, "abort on bad unit");
    for (int p = 0; p < 2; p++) begin
      lrt_initiator_model_i.send_reset(16'h0b00, 32'haaaa_0000 + 32'(p), 8'h00);
      chk_rsp(lrt_initiator_model_i.rsp_n, 16'h0b00, `LRT_RC_SUCCESS);
      chk(reply_path_identifier, 32'haaaa_0000 + 32'(p), "second path");
    end
  endtask

  task automatic t_tm;
    logic [7:0] codes [0:2] = '{8'h32, 8'h33, 8'h34};
    int n0;
    foreach (codes[i]) begin
      n0 = lrt_initiator_model_i.rsp_n;
      @(posedge hclk);
      tm_valid <= 1'b1;
      tm_code <= codes[i];
      tm_tag <= 16'h0100 + 16'(i);
      @(posedge hclk);
      tm_valid <= 1'b0;
      chk_rsp(n0, 16'h0100 + 16'(i), `LRT_RC_SUCCESS);
    end
  endtask

  task automatic t_cmd;
    int n0, r0;
    for (int q = 0; q < 2; q++) begin
      n0 = lrt_initiator_model_i.rsp_n;
      r0 = n_rej;
      @(posedge hclk);
      cmd_valid <= 1'b1;
      queue_type_field <= 3'(q);
      cmd_tag <= 16'h0c00;
      @(posedge hclk);
      cmd_valid <= 1'b0;
      if (q == 0) chk_rsp(n0, 16'h0c00, `LRT_RC_INVALID);
      else repeat (40) @(posedge hclk);
      chk(32'(n_rej - r0), 32'(q == 0), "reject");
      chk(32'(lrt_initiator_model_i.rsp_n - n0), 32'(q == 0), "command answer");
    end
  endtask

  task automatic t_link_sync;
    int a0, s0, v0;
    a0 = n_abort;
    link_reset <= 1'b1;
    repeat (20) @(posedge hclk);
    link_reset <= 1'b0;
    chk(32'(unit_attention), 32'h1, "link reset kept state");
    chk(32'(n_abort - a0), 32'h0, "link reset abort");
    ahb(1'b0, 32'(`LRT_ADDR_STAT), 32'h0);
    chk(rd, {8'hff, `LRT_RC_INVALID, 16'h0000}, "status word");
    ahb(1'b1, 32'(`LRT_ADDR_STAT), 32'hff00_0000);
    repeat (2) @(posedge hclk);
    chk(32'(unit_attention), 32'h0, "attention cleared");
    a0 = n_abort;
    hard_reset_req <= 1'b1;
    @(posedge hclk);
    hard_reset_req <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'(n_abort - a0), 32'h1, "hard reset abort");
    chk(32'(unit_attention), 32'h1, "hard reset attention");
    for (int r = 0; r < 3; r++) begin
      s0 = n_stx;
      v0 = n_servo;
      spindle_sync_role_field <= 2'(r);
      repeat (4) @(posedge hclk);
      rotation_tick <= 1'b1;
      sync_char_rx <= 1'b1;
      repeat (4) @(posedge hclk);
      rotation_tick <= 1'b0;
      sync_char_rx <= 1'b0;
      repeat (10) @(posedge hclk);
      chk(32'(n_stx - s0), 32'(r == 1), "sync origin");
      chk(32'(n_servo - v0), 32'(r == 2), "sync follow");
    end
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {hresetn, hsel, hwrite, tm_valid, cmd_valid, data_pending, link_reset, hard_reset_req} = '0;
    {sync_char_rx, rotation_tick, haddr, hwdata, tm_path, cmd_path, tm_tag, cmd_tag} = '0;
    {tm_code, hsize, queue_type_field, htrans, spindle_sync_role_field} = '0;
    {miscompares, checks, n_abort, n_rej, n_stx, n_servo} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_reset_ok();
    t_reset_bad();
    t_tm();
    t_cmd();
    t_link_sync();
    test_done();
  end

  initial begin
    #1_000_000;
    miscompares++;
    test_done();
  end
endmodule

// ===== design/lrt_defs.svh
// constants for the unit reset and task response block
`ifndef LRT_DEFS_SVH
`define LRT_DEFS_SVH
`define LRT_CLASS_CODE     8'h83
`define LRT_PC_LUN_RESET   8'h35
`define LRT_PC_RESPONSE    8'h03
`define LRT_RC_SUCCESS     8'h00
`define LRT_RC_NOT_FOUND   8'h01
`define LRT_RC_OVERLAP     8'h04
`define LRT_RC_NO_ACA      8'h20
`define LRT_RC_INVALID     8'hff
`define LRT_REQ_LEN        4'h9
`define LRT_RSP_LEN        3'h5
`define LRT_QT_UNTAGGED    3'h0
`define LRT_ADDR_CTRL      4'h0
`define LRT_ADDR_STAT      4'h4
`define LRT_ADDR_LUNMAP    4'h8
`define LRT_ADDR_PATH      4'hc
`define LRT_CTRL_RESET     8'h01
`define LRT_LUNMAP_RESET   8'h01
`endif

// ===== design/lrt_pkg.sv
// types for the unit reset and task response block
package lrt_pkg;
  typedef enum logic [2:0] {
    LRT_IDLE, LRT_RX, LRT_FLUSH, LRT_ABORT, LRT_TX
  } lrt_state_t;
endpackage

// ===== design/lrt_unit_reset.sv
// unit reset message decoder, per unit hard reset and response builder
// What this block does
// - reset aborts tasks, clears aca and releases reservations of that unit only
// - unit parameters return to saved values, else defaults
// - transport tables, alerts, event state and messages untouched
// - initiator stops data first; target flushes already requested data first
// - status for finished tasks before ack; none for aborted ones after
// - raise unit attention for all initiators, power-on or reset sense
// - exactly one response per unit reset message; code answers none that starts in LRT_FLUSH, LRT_ABORT or LRT_TX
// - request is nine bytes: class, code, tag, return path, unit
// - response goes over the requested return path
// - unsupported unit gives invalid field, otherwise success
// - response acknowledges all task management and bad commands; code drops those arriving while one is held, and bad commands with tm_valid
// - response is five bytes: class, code, tag, return code
// - return codes 00 01 04 20 ff, others reserved
// - spindle sync is a dedicated special character, may sit in frames
// - nominated node originates sync at rotation rate, others decode
// - forward user characters to other ports unless blocked
// - sync origination and processing follow the spindle role field
// - link reset leaves tasks, reservations and conditions alone
// - hard resets clear all tasks and reservations, restore saved state
// - untagged queue type is never accepted
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`include "lrt_defs.svh"
module lrt_unit_reset (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_valid,
  input  wire logic        rx_first,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        tm_valid,
  input  wire logic [7:0]  tm_code,
  input  wire logic [15:0] tm_tag,
  input  wire logic [31:0] tm_path,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  queue_type_field,
  input  wire logic [15:0] cmd_tag,
  input  wire logic [31:0] cmd_path,
  input  wire logic        data_pending,
  input  wire logic        link_reset,
  input  wire logic        hard_reset_req,
  input  wire logic        sync_char_rx,
  input  wire logic [1:0]  spindle_sync_role_field,
  input  wire logic        rotation_tick,
  output logic             tx_valid,
  output logic             tx_last,
  output logic      [7:0]  tx_byte,
  output logic      [31:0] reply_path_identifier,
  output logic             flush_req,
  output logic             unit_abort,
  output logic      [7:0]  abort_unit,
  output logic             status_block,
  output logic             unit_attention,
  output logic             sync_char_tx,
  output logic             sync_servo_pulse,
  output logic             user_char_forward_enable,
  output logic             cmd_reject
);
  lrt_pkg::lrt_state_t state;
  logic [3:0]  rx_cnt;
  logic [7:0]  req_code;
  logic [15:0] req_tag;
  logic [31:0] req_path;
  logic [7:0]  req_unit;
  logic [7:0]  lun_map;
  logic [7:0]  ctrl_fwd;
  logic [7:0]  ret_code;
  logic [15:0] rsp_tag;
  logic [2:0]  tx_cnt;
  logic [7:0]  ua_pending;
  logic        tm_pend;
  logic [7:0]  tm_pcode;
  logic [31:0] tm_ppath;
  logic [15:0] tm_ptag;
  logic        bus_wr;
  logic        bus_rd;
  logic [3:0]  bus_addr;
  logic        sync_s1;
  logic        sync_s2;
  logic        sync_s3;
  logic        rot_s1;
  logic        rot_s2;
  logic        rot_s3;
  logic        unit_ok;
  logic        addr_hit;
  logic        rx_done;
  logic [7:0]  next_ret_code;

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr   <= 1'b0;
      bus_rd   <= 1'b0;
      bus_addr <= 4'h0;
    end else if (clk_en && hready) begin
      bus_wr   <= hsel && htrans[1] && hwrite && addr_hit;
      bus_rd   <= hsel && htrans[1] && !hwrite;
      bus_addr <= haddr[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // lun map and forwarding control survive a link reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lun_map  <= `LRT_LUNMAP_RESET;
      ctrl_fwd <= `LRT_CTRL_RESET;
    end else if (clk_en && bus_wr) begin
      if (bus_addr == `LRT_ADDR_CTRL)
        ctrl_fwd <= hwdata[7:0];
      if (bus_addr == `LRT_ADDR_LUNMAP)
        lun_map <= hwdata[7:0];
    end
  end

  // read mux registered in the address phase for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite && !addr_hit) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[3:0])
        `LRT_ADDR_CTRL:   hrdata <= {24'h0, ctrl_fwd};
        `LRT_ADDR_STAT:   hrdata <= {ua_pending, ret_code, 13'h0, state};
        `LRT_ADDR_LUNMAP: hrdata <= {24'h0, lun_map};
        `LRT_ADDR_PATH:   hrdata <= req_path;
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // upper address bits must be zero, so the map does not alias across the space
  assign addr_hit = haddr[31:4] == 28'h0000000;
  // judged on the unit byte itself: req_unit only takes it at this same edge
  assign unit_ok  = (rx_byte < 8'h08) && lun_map[rx_byte[2:0]];
  assign rx_done  = rx_valid && (rx_cnt == `LRT_REQ_LEN - 4'h1);

  always_comb begin
    next_ret_code = unit_ok ? `LRT_RC_SUCCESS : `LRT_RC_INVALID;
    if (req_code != `LRT_PC_LUN_RESET)
      next_ret_code = `LRT_RC_INVALID;
  end

  // request byte capture, big-endian multi-byte fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt   <= 4'h0;
      req_code <= 8'h00;
      req_tag  <= 16'h0000;
      req_path <= 32'h0000_0000;
      req_unit <= 8'h00;
    end else if (clk_en && rx_valid && (state == lrt_pkg::LRT_IDLE ||
                 state == lrt_pkg::LRT_RX)) begin
      rx_cnt <= rx_first ? 4'h1 : rx_cnt + 4'h1;
      unique case (rx_first ? 4'h0 : rx_cnt)
        4'h1: req_code <= rx_byte;
        4'h2: req_tag  <= {rx_byte, req_tag[7:0]};
        4'h3: req_tag  <= {req_tag[15:8], rx_byte};
        4'h4, 4'h5, 4'h6, 4'h7: req_path <= {req_path[23:0], rx_byte};
        4'h8: req_unit <= rx_byte;
        default: req_code <= req_code;
      endcase
    end
  end

  // other task management and bad commands queue for a response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tm_pend  <= 1'b0;
      tm_pcode <= 8'h00;
      tm_ptag  <= 16'h0000;
      tm_ppath <= 32'h0000_0000;
      cmd_reject <= 1'b0;
    end else if (clk_en) begin
      cmd_reject <= cmd_valid && (queue_type_field == `LRT_QT_UNTAGGED);
      if (!tm_pend && tm_valid) begin
        tm_pend  <= 1'b1;
        tm_pcode <= tm_code;
        tm_ptag  <= tm_tag;
        tm_ppath <= tm_path;
      end else if (!tm_pend && cmd_valid && queue_type_field == `LRT_QT_UNTAGGED) begin
        tm_pend  <= 1'b1;
        tm_pcode <= `LRT_RC_INVALID;
        tm_ptag  <= cmd_tag;
        tm_ppath <= cmd_path;
      end else if (tm_pend && state == lrt_pkg::LRT_IDLE && !rx_valid) begin
        tm_pend <= 1'b0;
      end
    end
  end

  // unit reset sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= lrt_pkg::LRT_IDLE;
    end else if (clk_en) begin
      if (hard_reset_req) begin
        state <= lrt_pkg::LRT_IDLE;
      end else begin
        unique case (state)
          lrt_pkg::LRT_IDLE:
            if (rx_valid && rx_first)
              state <= lrt_pkg::LRT_RX;
            else if (tm_pend && !rx_valid)
              state <= lrt_pkg::LRT_TX;
          lrt_pkg::LRT_RX:
            if (rx_done)
              state <= (req_code == `LRT_PC_LUN_RESET && unit_ok) ?
                       lrt_pkg::LRT_FLUSH : lrt_pkg::LRT_TX;
          lrt_pkg::LRT_FLUSH:
            if (!data_pending)
              state <= lrt_pkg::LRT_ABORT;
          lrt_pkg::LRT_ABORT:
            state <= lrt_pkg::LRT_TX;
          lrt_pkg::LRT_TX:
            if (tx_cnt == `LRT_RSP_LEN - 3'h1)
              state <= lrt_pkg::LRT_IDLE;
        endcase
      end
    end
  end

  // response latch; link reset does not disturb it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_code <= `LRT_RC_SUCCESS;
      rsp_tag  <= 16'h0000;
      reply_path_identifier <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state == lrt_pkg::LRT_RX && rx_done) begin
        ret_code <= next_ret_code;
        rsp_tag  <= req_tag;
        reply_path_identifier <= req_path;
      end else if (state == lrt_pkg::LRT_IDLE && tm_pend && !rx_valid) begin
        ret_code <= (tm_pcode == `LRT_RC_INVALID) ? `LRT_RC_INVALID :
                    `LRT_RC_SUCCESS;
        rsp_tag  <= tm_ptag;
        reply_path_identifier <= tm_ppath;
      end
    end
  end

  // response byte stream, tag high byte first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt   <= 3'h0;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      tx_byte  <= 8'h00;
    end else if (clk_en) begin
      tx_valid <= state == lrt_pkg::LRT_TX;
      tx_last  <= state == lrt_pkg::LRT_TX && tx_cnt == `LRT_RSP_LEN - 3'h1;
      tx_cnt   <= (state == lrt_pkg::LRT_TX) ? tx_cnt + 3'h1 : 3'h0;
      unique case (tx_cnt)
        3'h0: tx_byte <= `LRT_CLASS_CODE;
        3'h1: tx_byte <= `LRT_PC_RESPONSE;
        3'h2: tx_byte <= rsp_tag[15:8];
        3'h3: tx_byte <= rsp_tag[7:0];
        default: tx_byte <= ret_code;
      endcase
    end
  end

  // abort, status gating and unit attention; transport state lives elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush_req      <= 1'b0;
      unit_abort     <= 1'b0;
      abort_unit     <= 8'h00;
      status_block   <= 1'b0;
      ua_pending     <= 8'h00;
      unit_attention <= 1'b0;
    end else if (clk_en) begin
      flush_req  <= state == lrt_pkg::LRT_FLUSH;
      unit_abort <= state == lrt_pkg::LRT_ABORT || hard_reset_req;
      if (state == lrt_pkg::LRT_ABORT)
        abort_unit <= req_unit;
      // aborted tasks may not post status once the ack is on the wire
      status_block <= state == lrt_pkg::LRT_ABORT ||
                      (status_block && state != lrt_pkg::LRT_IDLE);
      if (state == lrt_pkg::LRT_ABORT || hard_reset_req)
        ua_pending <= 8'hff;
      else if (bus_wr && bus_addr == `LRT_ADDR_STAT)
        ua_pending <= ua_pending & ~hwdata[31:24];
      unit_attention <= |ua_pending;
    end
  end

  // spindle sync: role 1 originates, role 2 follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      rot_s1  <= 1'b0;
      rot_s2  <= 1'b0;
      rot_s3  <= 1'b0;
      sync_char_tx     <= 1'b0;
      sync_servo_pulse <= 1'b0;
      user_char_forward_enable <= 1'b0;
    end else if (clk_en) begin
      sync_s1 <= sync_char_rx;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      rot_s1  <= rotation_tick;
      rot_s2  <= rot_s1;
      rot_s3  <= rot_s2;
      sync_char_tx <= spindle_sync_role_field == 2'h1 && rot_s2 && !rot_s3;
      sync_servo_pulse <= spindle_sync_role_field == 2'h2 && sync_s2 && !sync_s3;
      user_char_forward_enable <= ctrl_fwd[0];
    end
  end

  sequence s_ack_frame;
    tx_valid[*5] ##0 tx_last;
  endsequence
  sequence s_abort_step;
    clk_en && state == lrt_pkg::LRT_ABORT ##1 clk_en;
  endsequence

  a_ack_five_bytes: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tx_valid) && clk_en |-> s_ack_frame)
    else $error("response not five bytes");
  a_tag_high_first: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tx_valid) && clk_en |-> ##2 tx_byte == rsp_tag[15:8])
    else $error("tag high byte not third");
  a_link_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && link_reset && !hard_reset_req && state != lrt_pkg::LRT_ABORT |=> !unit_abort)
    else $error("link reset aborted tasks");
  a_ack_class: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tx_valid) |-> tx_byte == `LRT_CLASS_CODE)
    else $error("response class byte wrong");
  a_flush_first: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(unit_abort) && !$past(hard_reset_req) |-> $past(flush_req, 2) || $past(flush_req))
    else $error("abort before flush");
  a_ua_after: assert property (@(posedge hclk) disable iff (!hresetn)
    s_abort_step |-> ##1 unit_attention)
    else $error("no unit attention");
  a_status_block: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_valid && ret_code == `LRT_RC_SUCCESS && $past(status_block) |-> status_block)
    else $error("status unblocked during ack");
  a_untagged_rej: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && cmd_valid && queue_type_field == `LRT_QT_UNTAGGED |=> cmd_reject)
    else $error("untagged not rejected");
  a_bad_unit: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_last && ret_code == `LRT_RC_INVALID |-> !$past(unit_abort, 3))
    else $error("abort with invalid code");
  a_hard_rst: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && hard_reset_req |=> unit_abort && state == lrt_pkg::LRT_IDLE)
    else $error("hard reset missed");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 hreadyout && !hresp)
    else $error("bus not okay");
endmodule
